// ### verilog/nvmcc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module nvmcc_ctrl #(
	parameter int NVM_BYTES   = 16,
	parameter int CSUM_IDX    = NVM_BYTES - 1,
	parameter int COUNT_IDX   = NVM_BYTES - 2,
	parameter int PAGE_W      = 2,
	parameter int PROG_CYCLES = nvmcc_pkg::PROG_CYCLES,
	parameter int IDX_W       = $clog2(NVM_BYTES)
) (
	input  wire logic                    ref_clk,
	input  wire logic                    nrst,
	input  wire logic [7:0]              regAddr,
	input  wire logic [7:0]              regWrData,
	input  wire logic                    regWr,
	input  wire logic                    regRd,
	input  wire logic                    txnEnd,
	output logic      [7:0]              regRdData,
	output logic                         regRdAck,
	input  wire logic                    aonClkActive,
	input  wire logic [PAGE_W-1:0]       copyPageSel,
	output logic      [IDX_W-1:0]        eeAddr,
	input  wire logic [7:0]              eeRdData,
	output logic                         eeWrEn,
	output logic      [7:0]              eeWrData,
	output logic                         cfgWrEn,
	output logic      [IDX_W-1:0]        cfgWrAddr,
	output logic      [7:0]              cfgWrData,
	output logic      [IDX_W-1:0]        cfgRdAddr,
	input  wire logic [7:0]              cfgRdData,
	output logic                         sramWrEn,
	output logic      [PAGE_W+IDX_W-1:0] sramAddr,
	output logic      [7:0]              sramWrData,
	input  wire logic [7:0]              sramRdData
);
	localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(NVM_BYTES - 1);
	localparam logic [IDX_W-1:0] CSUM_I   = IDX_W'(CSUM_IDX);
	localparam logic [IDX_W-1:0] COUNT_I  = IDX_W'(COUNT_IDX);

	nvmcc_pkg::nvmcc_state_t state_r;
	nvmcc_pkg::nvmcc_state_t state_nxt;
	logic [IDX_W-1:0] idx_r;
	logic [23:0]      timer_r;
	logic [7:0]       storedCsum_r;
	logic [7:0]       loadCsum_r;
	logic [7:0]       progCount_r;
	logic [7:0]       liveCsum_r;
	logic             autoCsum_r;
	logic             crcErr_r;
	logic             loadReq_r;
	logic             unlockSeen_r;
	logic             unlockArmed_r;
	logic             crcClr;
	logic             crcEn;
	logic [7:0]       crcData;
	logic [7:0]       crcVal;
	logic [7:0]       progByte;
	logic             ctrlWr;
	logic             startProg;
	logic             startCopy;
	logic             loading;
	logic             progBusy;

	function automatic logic isState(input nvmcc_pkg::nvmcc_state_t s, input nvmcc_pkg::nvmcc_state_t t);
		return s == t;
	endfunction : isState

	assign ctrlWr    = regWr && (regAddr == nvmcc_pkg::NV_CTRL_ADDR);
	assign loading   = isState(state_r, nvmcc_pkg::ST_LD_A) || isState(state_r, nvmcc_pkg::ST_LD_D)
	                || isState(state_r, nvmcc_pkg::ST_LD_END);
	assign progBusy  = isState(state_r, nvmcc_pkg::ST_PG_A) || isState(state_r, nvmcc_pkg::ST_PG_D)
	                || isState(state_r, nvmcc_pkg::ST_PG_WAIT) || isState(state_r, nvmcc_pkg::ST_CT_A)
	                || isState(state_r, nvmcc_pkg::ST_CT_D);
	// Starts are taken only from idle with no load pending: no EEPROM access while busy
	assign startProg = ctrlWr && regWrData[nvmcc_pkg::CTRL_PROG_BIT] && unlockArmed_r
	                && isState(state_r, nvmcc_pkg::ST_IDLE) && !loadReq_r;
	assign startCopy = ctrlWr && regWrData[nvmcc_pkg::CTRL_COPY_BIT]
	                && isState(state_r, nvmcc_pkg::ST_IDLE) && !loadReq_r && !startProg;

	// Byte written to EEPROM: count slot is filled by hardware, checksum slot too when auto checksum is on
	always_comb begin
		progByte = sramRdData;
		if (idx_r == COUNT_I) begin
			progByte = (progCount_r == nvmcc_pkg::PROG_COUNT_MAX) ? progCount_r : progCount_r + 8'h01;
		end else if (idx_r == CSUM_I && autoCsum_r) begin
			progByte = crcVal;
		end
	end

	always_comb begin
		crcClr  = isState(state_r, nvmcc_pkg::ST_IDLE);
		crcEn   = 1'b0;
		crcData = eeRdData;
		if (isState(state_r, nvmcc_pkg::ST_LD_D)) begin
			crcEn = (idx_r != CSUM_I);
		end else if (isState(state_r, nvmcc_pkg::ST_PG_D)) begin
			crcEn   = (idx_r != CSUM_I);
			crcData = progByte;
		end
	end

	nvmcc_crc8 u_crc (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.clr     (crcClr),
		.en      (crcEn),
		.data    (crcData),
		.crc     (crcVal)
	);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			nvmcc_pkg::ST_IDLE: begin
				if (loadReq_r && aonClkActive) begin
					state_nxt = nvmcc_pkg::ST_LD_A;
				end else if (startProg) begin
					state_nxt = nvmcc_pkg::ST_PG_A;
				end else if (startCopy) begin
					state_nxt = nvmcc_pkg::ST_CP_A;
				end
			end
			nvmcc_pkg::ST_LD_A: begin
				if (aonClkActive) begin
					state_nxt = nvmcc_pkg::ST_LD_D;
				end
			end
			nvmcc_pkg::ST_LD_D: begin
				state_nxt = (idx_r == LAST_IDX) ? nvmcc_pkg::ST_LD_END : nvmcc_pkg::ST_LD_A;
			end
			nvmcc_pkg::ST_LD_END: state_nxt = nvmcc_pkg::ST_IDLE;
			nvmcc_pkg::ST_CP_A:   state_nxt = nvmcc_pkg::ST_CP_D;
			nvmcc_pkg::ST_CP_D: begin
				state_nxt = (idx_r == LAST_IDX) ? nvmcc_pkg::ST_IDLE : nvmcc_pkg::ST_CP_A;
			end
			nvmcc_pkg::ST_PG_A:   state_nxt = nvmcc_pkg::ST_PG_D;
			nvmcc_pkg::ST_PG_D: begin
				state_nxt = (idx_r == LAST_IDX) ? nvmcc_pkg::ST_PG_WAIT : nvmcc_pkg::ST_PG_A;
			end
			nvmcc_pkg::ST_PG_WAIT: begin
				if (timer_r == 24'(PROG_CYCLES - 1)) begin
					state_nxt = nvmcc_pkg::ST_CT_A;
				end
			end
			nvmcc_pkg::ST_CT_A:   state_nxt = nvmcc_pkg::ST_CT_D;
			nvmcc_pkg::ST_CT_D:   state_nxt = nvmcc_pkg::ST_IDLE;
			default:              state_nxt = nvmcc_pkg::ST_IDLE;
		endcase
	end

	// Sequencer, byte index and program-time counter
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= nvmcc_pkg::ST_IDLE;
			idx_r   <= '0;
			timer_r <= '0;
		end else begin
			state_r <= state_nxt;
			if (isState(state_r, nvmcc_pkg::ST_IDLE)) begin
				idx_r <= '0;
			end else if (isState(state_r, nvmcc_pkg::ST_LD_D) || isState(state_r, nvmcc_pkg::ST_CP_D)
			             || isState(state_r, nvmcc_pkg::ST_PG_D)) begin
				idx_r <= idx_r + 1'b1;
			end
			timer_r <= isState(state_r, nvmcc_pkg::ST_PG_WAIT) ? timer_r + 24'h000001 : 24'h000000;
		end
	end

	// Memory and register-file ports; read addresses lead read data by one cycle
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			eeAddr     <= '0;
			eeWrEn     <= 1'b0;
			eeWrData   <= 8'h00;
			cfgWrEn    <= 1'b0;
			cfgWrAddr  <= '0;
			cfgWrData  <= 8'h00;
			cfgRdAddr  <= '0;
			sramWrEn   <= 1'b0;
			sramAddr   <= '0;
			sramWrData <= 8'h00;
		end else begin
			eeWrEn   <= isState(state_r, nvmcc_pkg::ST_PG_D);
			cfgWrEn  <= isState(state_r, nvmcc_pkg::ST_LD_D);
			sramWrEn <= isState(state_r, nvmcc_pkg::ST_CP_D);
			if (isState(state_r, nvmcc_pkg::ST_LD_A)) begin
				eeAddr <= idx_r;
			end
			if (isState(state_r, nvmcc_pkg::ST_CT_A)) begin
				eeAddr <= COUNT_I;
			end
			if (isState(state_r, nvmcc_pkg::ST_LD_D)) begin
				cfgWrAddr <= idx_r;
				cfgWrData <= eeRdData;
			end
			if (isState(state_r, nvmcc_pkg::ST_CP_A)) begin
				cfgRdAddr <= idx_r;
			end
			if (isState(state_r, nvmcc_pkg::ST_CP_A) || isState(state_r, nvmcc_pkg::ST_PG_A)) begin
				sramAddr <= {copyPageSel, idx_r};
			end
			if (isState(state_r, nvmcc_pkg::ST_CP_D)) begin
				sramWrData <= cfgRdData;
			end
			if (isState(state_r, nvmcc_pkg::ST_PG_D)) begin
				eeAddr   <= idx_r;
				eeWrData <= progByte;
			end
		end
	end

	// Checksums, counter and error flag
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			storedCsum_r <= nvmcc_pkg::STORED_CSUM_RST;
			loadCsum_r   <= nvmcc_pkg::STORED_CSUM_RST;
			progCount_r  <= nvmcc_pkg::PROG_COUNT_RST;
			liveCsum_r   <= nvmcc_pkg::LIVE_CSUM_RST;
			crcErr_r     <= 1'b0;
		end else begin
			if (isState(state_r, nvmcc_pkg::ST_LD_D) && idx_r == CSUM_I) begin
				loadCsum_r   <= eeRdData;
				storedCsum_r <= eeRdData;
			end
			if (isState(state_r, nvmcc_pkg::ST_LD_D) && idx_r == COUNT_I) begin
				progCount_r <= eeRdData;
			end
			if (isState(state_r, nvmcc_pkg::ST_CT_D)) begin
				progCount_r <= eeRdData;
			end
			if (isState(state_r, nvmcc_pkg::ST_PG_D) && idx_r == CSUM_I) begin
				storedCsum_r <= progByte;
			end
			if (isState(state_r, nvmcc_pkg::ST_LD_END)) begin
				liveCsum_r <= crcVal;
				crcErr_r   <= (crcVal != loadCsum_r);
			end else if (isState(state_r, nvmcc_pkg::ST_LD_A) && idx_r == '0) begin
				crcErr_r <= 1'b0;
			end
		end
	end

	// Control bits written by software
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			autoCsum_r <= nvmcc_pkg::AUTO_CSUM_RST;
			loadReq_r  <= 1'b1;
		end else begin
			if (ctrlWr) begin
				autoCsum_r <= regWrData[nvmcc_pkg::CTRL_AUTO_BIT];
			end
			// New request wins over the clear when both land together
			if (ctrlWr && regWrData[nvmcc_pkg::CTRL_LOAD_BIT] && !progBusy) begin
				loadReq_r <= 1'b1;
			end else if (isState(state_r, nvmcc_pkg::ST_IDLE) && aonClkActive) begin
				loadReq_r <= 1'b0;
			end
		end
	end

	// Unlock is valid only for the transaction right after the one that wrote it
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			unlockSeen_r  <= 1'b0;
			unlockArmed_r <= 1'b0;
		end else begin
			if (txnEnd) begin
				unlockArmed_r <= unlockSeen_r || (regWr && regAddr == nvmcc_pkg::PROG_UNLOCK_ADDR
				                 && regWrData == nvmcc_pkg::PROG_UNLOCK_CODE);
				unlockSeen_r  <= 1'b0;
			end else if (regWr) begin
				unlockSeen_r <= (regAddr == nvmcc_pkg::PROG_UNLOCK_ADDR)
				             && (regWrData == nvmcc_pkg::PROG_UNLOCK_CODE);
			end
		end
	end

	// Read port: answers one cycle later, withheld while a load is pending or runs
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			regRdData <= 8'h00;
			regRdAck  <= 1'b0;
		end else begin
			regRdAck <= 1'b0;
			if (regRd && !loading && !loadReq_r) begin
				regRdAck <= 1'b1;
				case (regAddr)
					nvmcc_pkg::STORED_CSUM_ADDR: regRdData <= storedCsum_r;
					nvmcc_pkg::PROG_COUNT_ADDR:  regRdData <= progCount_r;
					nvmcc_pkg::LIVE_CSUM_ADDR:   regRdData <= liveCsum_r;
					nvmcc_pkg::NV_CTRL_ADDR: begin
						regRdData <= 8'h00;
						regRdData[nvmcc_pkg::CTRL_COPY_BIT]   <= isState(state_r, nvmcc_pkg::ST_CP_A)
						                                       || isState(state_r, nvmcc_pkg::ST_CP_D);
						regRdData[nvmcc_pkg::CTRL_CRCERR_BIT] <= crcErr_r;
						regRdData[nvmcc_pkg::CTRL_AUTO_BIT]   <= autoCsum_r;
						regRdData[nvmcc_pkg::CTRL_BUSY_BIT]   <= progBusy;
					end
					default: begin
						regRdData <= 8'h00;
						regRdAck  <= 1'b0;
					end
				endcase
			end
		end
	end
endmodule : nvmcc_ctrl
`default_nettype wire

// ### shared/nvmcc_pkg.sv
package nvmcc_pkg;
	// Register offsets on the serial register port
	localparam logic [7:0] STORED_CSUM_ADDR = 8'h87;
	localparam logic [7:0] PROG_COUNT_ADDR  = 8'h88;
	localparam logic [7:0] NV_CTRL_ADDR     = 8'h89;
	localparam logic [7:0] LIVE_CSUM_ADDR   = 8'h8a;
	localparam logic [7:0] PROG_UNLOCK_ADDR = 8'h8f;
	localparam logic [7:0] PROG_UNLOCK_CODE = 8'hbe;
	// Control register field positions
	localparam int CTRL_COPY_BIT  = 6;
	localparam int CTRL_CRCERR_BIT = 5;
	localparam int CTRL_AUTO_BIT  = 4;
	localparam int CTRL_LOAD_BIT  = 3;
	localparam int CTRL_BUSY_BIT  = 2;
	localparam int CTRL_PROG_BIT  = 0;
	// Reset values and program-count limit
	localparam logic [7:0] STORED_CSUM_RST = 8'h00;
	localparam logic [7:0] PROG_COUNT_RST  = 8'h00;
	localparam logic [7:0] LIVE_CSUM_RST   = 8'h00;
	localparam logic       AUTO_CSUM_RST   = 1'b1;
	localparam logic [7:0] PROG_COUNT_MAX  = 8'hff;
	// Checksum generator
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'h00;
	// Timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int PROG_TIME_MS  = 230;
	localparam int PROG_CYCLES   = PROG_TIME_MS * (1000000 / CLK_PERIOD_NS);
	// Sequencer states
	typedef enum logic [10:0] {
		ST_IDLE  = 11'h001,
		ST_LD_A  = 11'h002,
		ST_LD_D  = 11'h004,
		ST_LD_END = 11'h008,
		ST_CP_A  = 11'h010,
		ST_CP_D  = 11'h020,
		ST_PG_A  = 11'h040,
		ST_PG_D  = 11'h080,
		ST_PG_WAIT = 11'h100,
		ST_CT_A  = 11'h200,
		ST_CT_D  = 11'h400
	} nvmcc_state_t;
endpackage : nvmcc_pkg

// ### verilog/nvmcc_crc8.sv
`timescale 1ns/1ps
`default_nettype none
module nvmcc_crc8 (
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	input  wire logic       clr,
	input  wire logic       en,
	input  wire logic [7:0] data,
	output logic      [7:0] crc
);
	logic [7:0] crc_r;

	function automatic logic [7:0] crcStep(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] x;
		x = c ^ d;
		for (int i = 0; i < 8; i++) begin
			x = x[7] ? ((x << 1) ^ nvmcc_pkg::CRC_POLY) : (x << 1);
		end
		return x;
	endfunction : crcStep

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			crc_r <= nvmcc_pkg::CRC_INIT;
		end else if (clr) begin
			crc_r <= nvmcc_pkg::CRC_INIT;
		end else if (en) begin
			crc_r <= crcStep(crc_r, data);
		end
	end

	assign crc = crc_r;
endmodule : nvmcc_crc8
`default_nettype wire

// ### verification/nvmcc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module nvmcc_mem_model (
	input  wire logic       ref_clk,
	input  wire logic [3:0] eeAddr,
	output logic      [7:0] eeRdData,
	input  wire logic       eeWrEn,
	input  wire logic [7:0] eeWrData,
	input  wire logic       cfgWrEn,
	input  wire logic [3:0] cfgWrAddr,
	input  wire logic [7:0] cfgWrData,
	input  wire logic [3:0] cfgRdAddr,
	output logic      [7:0] cfgRdData,
	input  wire logic       sramWrEn,
	input  wire logic [5:0] sramAddr,
	input  wire logic [7:0] sramWrData,
	output logic      [7:0] sramRdData
);
	logic [7:0] ee   [16];
	logic [7:0] cfg  [16];
	logic [7:0] sram [64];

	initial begin
		for (int i = 0; i < 16; i++) begin
			ee[i] = 8'h10 + 8'(i);
		end
		ee[14] = 8'hfe;
		ee[15] = 8'h00;
	end

	// Reads follow the registered address in the same cycle; the sequencer samples one state later
	assign eeRdData   = ee[eeAddr];
	assign cfgRdData  = cfg[cfgRdAddr];
	assign sramRdData = sram[sramAddr];

	// Arrays keep contents through nrst, as the real cells do
	always @(posedge ref_clk) begin
		if (eeWrEn) ee[eeAddr] <= eeWrData;
		if (cfgWrEn) cfg[cfgWrAddr] <= cfgWrData;
		if (sramWrEn) sram[sramAddr] <= sramWrData;
	end
endmodule : nvmcc_mem_model
`default_nettype wire

// ### verification/nvmcc_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module nvmcc_ctrl_checker #(
	parameter int NVM_BYTES = 16,
	parameter int PAGE_W    = 2,
	parameter int IDX_W     = 4
) (
	input  wire logic                    ref_clk,
	input  wire logic                    nrst,
	input  wire logic [7:0]              regAddr,
	input  wire logic                    regRd,
	input  wire logic                    regRdAck,
	input  wire logic                    aonClkActive,
	input  wire logic [PAGE_W-1:0]       copyPageSel,
	input  wire logic [IDX_W-1:0]        eeAddr,
	input  wire logic                    eeWrEn,
	input  wire logic                    cfgWrEn,
	input  wire logic                    sramWrEn,
	input  wire logic [PAGE_W+IDX_W-1:0] sramAddr
);
	default clocking dc @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	sequence s_aon_off;
		!aonClkActive [*3];
	endsequence
	sequence s_wr_pair;
		eeWrEn ##2 eeWrEn;
	endsequence

	property p_ack_src;
		regRdAck |-> $past(regRd);
	endproperty
	property p_ack_map;
		regRdAck |-> ($past(regAddr) inside {8'h87, 8'h88, 8'h89, 8'h8a});
	endproperty
	property p_load_quiet;
		cfgWrEn |-> !regRdAck;
	endproperty
	property p_aon_stall;
		s_aon_off |-> !cfgWrEn;
	endproperty
	property p_prog_excl;
		eeWrEn |-> !cfgWrEn && !sramWrEn;
	endproperty
	property p_ee_pace;
		eeWrEn |=> !eeWrEn;
	endproperty
	property p_ee_step;
		s_wr_pair |-> eeAddr == $past(eeAddr, 2) + 1'h1;
	endproperty
	property p_copy_page;
		sramWrEn |-> sramAddr[PAGE_W+IDX_W-1:IDX_W] == copyPageSel;
	endproperty
	// Last byte must be followed by the long cell wait, not more writes
	property p_prog_wait;
		eeWrEn && eeAddr == IDX_W'(NVM_BYTES - 1) |=> !eeWrEn [*8];
	endproperty

	a_ack_src: assert property (p_ack_src)
		else $error("read answer without read request");
	a_ack_map: assert property (p_ack_map)
		else $error("read answer for unmapped address");
	a_load_quiet: assert property (p_load_quiet)
		else $error("read answered during load");
	a_aon_stall: assert property (p_aon_stall)
		else $error("load advanced without always-on clock");
	a_prog_excl: assert property (p_prog_excl)
		else $error("other access during programming");
	a_ee_pace: assert property (p_ee_pace)
		else $error("back to back cell writes");
	a_ee_step: assert property (p_ee_step)
		else $error("cell write address not sequential");
	a_copy_page: assert property (p_copy_page)
		else $error("copy went to wrong page");
	a_prog_wait: assert property (p_prog_wait)
		else $error("write soon after checksum byte");
endmodule : nvmcc_ctrl_checker
`default_nettype wire

// ### verification/nvmcc_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module nvmcc_ctrl_tb;
	localparam logic [7:0] CTL = nvmcc_pkg::NV_CTRL_ADDR;
	logic       ref_clk = 1'h0;
	logic       nrst = 1'h0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic       regWr = 1'h0;
	logic       regRd = 1'h0;
	logic       txnEnd = 1'h0;
	logic       aonClkActive = 1'h1;
	logic [1:0] copyPageSel = 2'h2;
	logic [7:0] regRdData, eeRdData, eeWrData, cfgWrData, cfgRdData, sramWrData, sramRdData;
	logic       regRdAck, eeWrEn, cfgWrEn, sramWrEn;
	logic [3:0] eeAddr, cfgWrAddr, cfgRdAddr;
	logic [5:0] sramAddr;
	logic [7:0] img [16];
	logic [7:0] d;
	logic [7:0] ctl;
	logic       k;
	int         mismatches = 0;
	int         comparisons = 0;

	always #12.5 ref_clk = ~ref_clk;

	nvmcc_ctrl #(.PROG_CYCLES(20)) uut (.ref_clk, .nrst, .regAddr, .regWrData, .regWr, .regRd, .txnEnd,
		.regRdData, .regRdAck, .aonClkActive, .copyPageSel, .eeAddr, .eeRdData, .eeWrEn, .eeWrData, .cfgWrEn,
		.cfgWrAddr, .cfgWrData, .cfgRdAddr, .cfgRdData, .sramWrEn, .sramAddr, .sramWrData, .sramRdData);
	nvmcc_mem_model mem (.ref_clk, .eeAddr, .eeRdData, .eeWrEn, .eeWrData, .cfgWrEn, .cfgWrAddr, .cfgWrData,
		.cfgRdAddr, .cfgRdData, .sramWrEn, .sramAddr, .sramWrData, .sramRdData);

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [7:0] csum();
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < 15; i++) begin
			c = c ^ img[i];
			for (int b = 0; b < 8; b++) begin
				c = c[7] ? {c[6:0], 1'h0} ^ 8'h07 : {c[6:0], 1'h0};
			end
		end
		return c;
	endfunction : csum

	// Every access is its own transaction, so an unlock only arms the next one
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge ref_clk);
		regAddr = a;
		regWrData = v;
		regWr = 1'h1;
		@(negedge ref_clk);
		regWr = 1'h0;
		txnEnd = 1'h1;
		@(negedge ref_clk);
		txnEnd = 1'h0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(negedge ref_clk);
		regAddr = a;
		regRd = 1'h1;
		@(negedge ref_clk);
		regRd = 1'h0;
		k = regRdAck;
		d = regRdData;
		txnEnd = 1'h1;
		@(negedge ref_clk);
		txnEnd = 1'h0;
	endtask : rd

	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		rd(a);
		chk({7'h00, k}, 8'h01);
		chk(d, exp);
	endtask : rdc

	task automatic idle();
		for (int n = 0; n < 60; n++) begin
			rd(CTL);
			if (k === 1'h1 && d[2] === 1'h0 && d[6] === 1'h0) return;
		end
		chk(8'h01, 8'h00);
	endtask : idle

	initial begin
		for (int i = 0; i < 16; i++) begin
			img[i] = 8'h10 + 8'(i);
		end
		img[14] = 8'hfe;
		img[15] = 8'h00;
		repeat (2) @(negedge ref_clk);
		nrst = 1'h1;
		rd(CTL);
		chk({7'h00, k}, 8'h00);
		idle();
		ctl = {2'h0, csum() != 8'h00, 5'h10};
		rdc(CTL, ctl);
		rdc(nvmcc_pkg::LIVE_CSUM_ADDR, csum());
		rdc(nvmcc_pkg::STORED_CSUM_ADDR, 8'h00);
		rdc(nvmcc_pkg::PROG_COUNT_ADDR, 8'hfe);
		for (int i = 0; i < 16; i++) chk(mem.cfg[i], img[i]);
		wr(CTL, 8'h11);
		rdc(CTL, ctl);
		// Any transaction between unlock and start disarms the unlock
		wr(nvmcc_pkg::PROG_UNLOCK_ADDR, nvmcc_pkg::PROG_UNLOCK_CODE);
		rd(CTL);
		wr(CTL, 8'h11);
		rdc(CTL, ctl);
		wr(CTL, 8'h50);
		rdc(CTL, ctl | 8'h40);
		idle();
		rdc(CTL, ctl);
		for (int i = 0; i < 16; i++) chk(mem.sram[{copyPageSel, 4'(i)}], img[i]);
		img[14] = 8'hff;
		img[15] = csum();
		// Second pass starts from 255 and must stay there
		repeat (2) begin
			wr(nvmcc_pkg::PROG_UNLOCK_ADDR, nvmcc_pkg::PROG_UNLOCK_CODE);
			wr(CTL, 8'h11);
			rdc(CTL, ctl | 8'h04);
			idle();
			rdc(nvmcc_pkg::PROG_COUNT_ADDR, 8'hff);
			rdc(nvmcc_pkg::STORED_CSUM_ADDR, img[15]);
		end
		for (int i = 0; i < 16; i++) chk(mem.ee[i], img[i]);
		aonClkActive = 1'h0;
		wr(CTL, 8'h18);
		repeat (40) @(negedge ref_clk);
		rd(CTL);
		chk({7'h00, k}, 8'h00);
		// Let the load run a few bytes, then stop the clock in mid-load
		aonClkActive = 1'h1;
		repeat (6) @(negedge ref_clk);
		aonClkActive = 1'h0;
		repeat (40) @(negedge ref_clk);
		rd(CTL);
		chk({7'h00, k}, 8'h00);
		aonClkActive = 1'h1;
		idle();
		rdc(CTL, 8'h10);
		rdc(nvmcc_pkg::LIVE_CSUM_ADDR, img[15]);
		rdc(nvmcc_pkg::PROG_COUNT_ADDR, 8'hff);
		wr(CTL, 8'h92);
		rdc(CTL, 8'h10);
		wr(CTL, 8'h00);
		rdc(CTL, 8'h00);
		// Auto checksum off: the checksum byte comes straight from the source page
		wr(nvmcc_pkg::PROG_UNLOCK_ADDR, nvmcc_pkg::PROG_UNLOCK_CODE);
		wr(CTL, 8'h01);
		idle();
		rdc(nvmcc_pkg::STORED_CSUM_ADDR, 8'h00);
		chk(mem.ee[15], 8'h00);
		rdc(nvmcc_pkg::PROG_COUNT_ADDR, 8'hff);
		complete_run();
	end

	// Whole sequence needs well under 1500 cycles
	initial begin
		#(25 * 4000);
		mismatches++;
		complete_run();
	end
endmodule : nvmcc_ctrl_tb

bind nvmcc_ctrl nvmcc_ctrl_checker #(.NVM_BYTES(NVM_BYTES), .PAGE_W(PAGE_W), .IDX_W(IDX_W)) chk_i (.ref_clk,
	.nrst, .regAddr, .regRd, .regRdAck, .aonClkActive, .copyPageSel, .eeAddr, .eeWrEn, .cfgWrEn, .sramWrEn,
	.sramAddr);
`default_nettype wire
